/* design/fsb_cmd.sv */
`default_nettype none
// Behaviour
// - 26h address width follows wide bit; 25h wide
// - Only one open sector at a time
// - Address bits below sector boundary ignored
// - Open only inside protected blocks
// - 24h closes the last opened sector
// - Boot stream armed at end of reset
// - Start delay from four-bit field; host silent
// - Quad lines bit picks boot stream width
// - Stream until select rises after a full byte; then normal mode
// - Boot stream not rearmed until reset
// - Boot config holds address, delay, enable
// - 14h reads config, low byte first, repeats
// - 15h writes config, needs write permit latch
// - Config write only with exactly 32 bits
// - Pending during write, then latch cleared
// - 16h/C8h read volatile bank, repeating
// - Bank read uses one or four lines
// - 18h writes persistent and volatile bank
// - C5h needs permit; 17h does not
// - Wide bit zero: bank supplies high address for 26h
// - Pending during bank writes; all eight bits stored as sent
// - B7h/29h set/clear wide bit freely
module fsb_cmd #(
	parameter int WRITE_CYC = fsb_pkg::WRITE_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_soft_reset,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io_in,
	output logic [3:0] o_io_out,
	output logic [3:0] o_io_oe,
	input wire logic i_four_line_command_mode,
	input wire logic i_quad_lines_on,
	input wire logic [3:0] i_block_protect_level,
	input wire logic i_top_bottom_select,
	input wire logic [7:0] i_boot_data,
	output logic [23:0] o_boot_byte_index,
	output logic [31:0] o_boot_config,
	output logic o_boot_armed,
	output logic o_op_pending,
	output logic o_write_permit_latch,
	output logic o_wide_address_on,
	output logic [7:0] o_bank_nonvolatile,
	output logic o_sector_open_valid,
	output logic [19:0] o_sector_open_addr
);
	// ==========================================================
	// Helpers
	// Byte order swap: register low byte travels first on the wire
	function automatic logic [31:0] swap32(input logic [31:0] w);
		swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	// Block lies in the top or bottom protected range
	function automatic logic blk_prot(input logic [31:0] a,
		input logic [3:0] bp, input logic tb);
		logic [10:0] n;
		logic [10:0] blk;
		n = 11'h001 << (bp - 4'h1);
		blk = {1'b0, a[fsb_pkg::BLOCK_MSB:fsb_pkg::BLOCK_LSB]};
		if (bp == 4'h0) begin
			blk_prot = 1'b0;
		end else if (bp > 4'hA) begin
			blk_prot = 1'b1;
		end else if (tb) begin
			blk_prot = blk < n;
		end else begin
			blk_prot = blk >= (fsb_pkg::BLOCK_COUNT - n);
		end
	endfunction

	function automatic fsb_pkg::fsb_cmd_type decode(input logic [7:0] op);
		if (op == fsb_pkg::OP_SECTOR_OPEN) begin
			decode = fsb_pkg::FSB_CMD_OPEN;
		end else if (op == fsb_pkg::OP_SECTOR_OPEN_WIDE) begin
			decode = fsb_pkg::FSB_CMD_OPEN_WIDE;
		end else if (op == fsb_pkg::OP_SECTOR_CLOSE) begin
			decode = fsb_pkg::FSB_CMD_CLOSE;
		end else if (op == fsb_pkg::OP_BOOT_CFG_WRITE) begin
			decode = fsb_pkg::FSB_CMD_CFG_WRITE;
		end else if (op == fsb_pkg::OP_BANK_WRITE_PERSIST) begin
			decode = fsb_pkg::FSB_CMD_BANK_PERSIST;
		end else if (op == fsb_pkg::OP_BANK_WRITE_TEMP) begin
			decode = fsb_pkg::FSB_CMD_BANK_TEMP;
		end else if (op == fsb_pkg::OP_BANK_WRITE_TEMP_FREE) begin
			decode = fsb_pkg::FSB_CMD_BANK_FREE;
		end else if (op == fsb_pkg::OP_WIDE_ENTER) begin
			decode = fsb_pkg::FSB_CMD_WIDE_ENTER;
		end else if (op == fsb_pkg::OP_WIDE_LEAVE) begin
			decode = fsb_pkg::FSB_CMD_WIDE_LEAVE;
		end else if (op == fsb_pkg::OP_WRITE_PERMIT) begin
			decode = fsb_pkg::FSB_CMD_PERMIT;
		end else begin
			decode = fsb_pkg::FSB_CMD_NONE;
		end
	endfunction

	logic [31:0] boot_cfg_ff;
	logic [7:0] bank_vol_ff;
	logic [7:0] bank_nv_ff;
	logic boot_armed_ff;
	logic rearm_ff;
	logic permit_ff;
	logic pend_ff;
	logic [15:0] pend_cnt_ff;
	logic open_valid_ff;
	logic [19:0] open_addr_ff;

	// ==========================================================
	// Link side: capture on rising sck, drive on falling sck
	// Register words read here are quasi-static: they only change
	// after select has risen, long before the next frame starts.
	logic new_ff;
	logic [7:0] cnt_ff;
	logic long_ff;
	logic [39:0] sr_ff;
	logic [7:0] op_ff;
	logic boot_frame_ff;
	logic [26:0] obits_ff;
	logic [7:0] nxt_cnt;
	logic nxt_long;
	logic [39:0] nxt_sr;
	logic [7:0] nxt_op;
	logic nxt_boot;
	logic [26:0] nxt_obits;
	logic [7:0] dly_p1;

	assign dly_p1 = {4'h0, boot_cfg_ff[fsb_pkg::BOOT_DLY_MSB:
		fsb_pkg::BOOT_DLY_LSB]} + 8'h01;

	// Frame start marker, set by select itself since sck is idle then
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			new_ff <= 1'b1;
		end else begin
			new_ff <= 1'b0;
		end
	end

	// Bit counting wraps by one repeat unit so reads repeat forever
	always_comb begin
		logic [7:0] base;
		logic [7:0] stp;
		logic [7:0] sum;
		base = new_ff ? 8'h00 : cnt_ff;
		nxt_boot = new_ff ? boot_armed_ff : boot_frame_ff;
		stp = (!nxt_boot && i_four_line_command_mode) ? 8'h04 : 8'h01;
		sum = base + stp;
		nxt_long = new_ff ? 1'b0 : long_ff;
		nxt_cnt = sum;
		if (sum >= fsb_pkg::CNT_WRAP) begin
			nxt_cnt = sum - fsb_pkg::REPEAT_BITS;
			nxt_long = 1'b1;
		end
		if (i_four_line_command_mode) begin
			nxt_sr = {sr_ff[35:0], i_io_in};
		end else begin
			nxt_sr = {sr_ff[38:0], i_io_in[0]};
		end
		if (new_ff) begin
			nxt_sr = i_four_line_command_mode ? {36'h0, i_io_in}
				: {39'h0, i_io_in[0]};
		end
		nxt_op = new_ff ? 8'h00 : op_ff;
		if (!nxt_boot && base < fsb_pkg::OPCODE_BITS
			&& sum >= fsb_pkg::OPCODE_BITS) begin
			nxt_op = nxt_sr[7:0];
		end
		// A data bit was driven on the last falling edge
		nxt_obits = new_ff ? 27'h0 : obits_ff;
		if (!new_ff && boot_frame_ff && cnt_ff >= dly_p1) begin
			nxt_obits = obits_ff + (i_quad_lines_on ? 27'h4 : 27'h1);
		end
	end

	always_ff @(posedge i_sck) begin
		cnt_ff <= nxt_cnt;
		long_ff <= nxt_long;
		sr_ff <= nxt_sr;
		op_ff <= nxt_op;
		boot_frame_ff <= nxt_boot;
		obits_ff <= nxt_obits;
	end

	assign o_boot_byte_index = obits_ff[26:3];

	// Output drive; released at once when select rises
	always_ff @(negedge i_sck or posedge i_cs_n) begin
		logic [31:0] word;
		logic [7:0] idx;
		word = 32'h0000_0000;
		idx = cnt_ff - fsb_pkg::OPCODE_BITS;
		if (op_ff == fsb_pkg::OP_BOOT_CFG_READ) begin
			word = swap32(boot_cfg_ff) << idx[4:0];
		end else begin
			word = {4{bank_vol_ff}} << idx[4:0];
		end
		if (i_cs_n) begin
			o_io_out <= 4'h0;
			o_io_oe <= 4'h0;
		end else if (boot_frame_ff) begin
			if (cnt_ff < dly_p1) begin
				o_io_out <= 4'h0;
				o_io_oe <= 4'h0;
			end else if (i_quad_lines_on) begin
				o_io_out <= obits_ff[2] ? i_boot_data[3:0]
					: i_boot_data[7:4];
				o_io_oe <= 4'hF;
			end else begin
				o_io_out <= {2'b00, i_boot_data[3'h7 - obits_ff[2:0]], 1'b0};
				o_io_oe <= 4'h2;
			end
		end else if (cnt_ff >= fsb_pkg::OPCODE_BITS
			&& (op_ff == fsb_pkg::OP_BOOT_CFG_READ
			|| op_ff == fsb_pkg::OP_BANK_READ
			|| op_ff == fsb_pkg::OP_BANK_READ_ALT)) begin
			if (i_four_line_command_mode) begin
				o_io_out <= word[31:28];
				o_io_oe <= 4'hF;
			end else begin
				o_io_out <= {2'b00, word[31], 1'b0};
				o_io_oe <= 4'h2;
			end
		end else begin
			o_io_out <= 4'h0;
			o_io_oe <= 4'h0;
		end
	end

	// ==========================================================
	// Control side: frame ends when synchronised select rises
	logic cs_s1_ff;
	logic cs_s2_ff;
	logic cs_s3_ff;
	logic commit;
	fsb_pkg::fsb_cmd_type cmd;
	logic [31:0] open_addr;
	logic needs_permit;
	logic len_ok;
	logic accept;
	logic write_done;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
		end else begin
			cs_s1_ff <= i_cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
		end
	end

	// Link words are stable here: sck has stopped with select high
	always_comb begin
		commit = cs_s2_ff && !cs_s3_ff && !boot_frame_ff
			&& !long_ff;
		cmd = decode(op_ff);
		if (cmd == fsb_pkg::FSB_CMD_OPEN
			&& !bank_vol_ff[fsb_pkg::BANK_WIDE_BIT]) begin
			open_addr = {1'b0, bank_vol_ff[6:0], sr_ff[23:0]};
		end else begin
			open_addr = sr_ff[31:0];
		end
		needs_permit = cmd == fsb_pkg::FSB_CMD_CFG_WRITE
			|| cmd == fsb_pkg::FSB_CMD_BANK_PERSIST
			|| cmd == fsb_pkg::FSB_CMD_BANK_TEMP;
		if (cmd == fsb_pkg::FSB_CMD_OPEN) begin
			len_ok = cnt_ff == (bank_vol_ff[fsb_pkg::BANK_WIDE_BIT] ?
				fsb_pkg::WIDE_FRAME_BITS
				: fsb_pkg::NARROW_ADDR_FRAME_BITS);
		end else if (cmd == fsb_pkg::FSB_CMD_OPEN_WIDE
			|| cmd == fsb_pkg::FSB_CMD_CFG_WRITE) begin
			len_ok = cnt_ff == fsb_pkg::WIDE_FRAME_BITS;
		end else if (needs_permit || cmd == fsb_pkg::FSB_CMD_BANK_FREE)
		begin
			len_ok = cnt_ff == fsb_pkg::BANK_FRAME_BITS;
		end else begin
			len_ok = cnt_ff == fsb_pkg::OPCODE_BITS;
		end
		// Writes are refused while one is pending; 15h/18h/C5h also while unpermitted
		accept = commit && len_ok && !pend_ff
			&& (!needs_permit || permit_ff);
		write_done = pend_ff && pend_cnt_ff == 16'h0001;
	end

	// Write-busy timer for config and bank writes
	always_ff @(posedge i_mclk) begin
		if (i_srst || i_soft_reset) begin
			pend_ff <= 1'b0;
			pend_cnt_ff <= 16'h0000;
		end else if (accept && (needs_permit
			|| cmd == fsb_pkg::FSB_CMD_BANK_FREE)) begin
			pend_ff <= 1'b1;
			pend_cnt_ff <= 16'(WRITE_CYC);
		end else if (write_done) begin
			pend_ff <= 1'b0;
			pend_cnt_ff <= 16'h0000;
		end else if (pend_ff) begin
			pend_cnt_ff <= pend_cnt_ff - 16'h0001;
		end
	end

	// Write permit latch; cleared when any pending write ends, 17h included
	always_ff @(posedge i_mclk) begin
		if (i_srst || i_soft_reset) begin
			permit_ff <= 1'b0;
		end else if (write_done) begin
			permit_ff <= 1'b0;
		end else if (accept && cmd == fsb_pkg::FSB_CMD_PERMIT) begin
			permit_ff <= 1'b1;
		end
	end

	// Persistent registers survive a software reset
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			boot_cfg_ff <= fsb_pkg::BOOT_CFG_RST;
			bank_nv_ff <= fsb_pkg::BANK_NV_RST;
		end else if (accept && cmd == fsb_pkg::FSB_CMD_CFG_WRITE) begin
			boot_cfg_ff <= swap32(sr_ff[31:0]);
		end else if (accept && cmd == fsb_pkg::FSB_CMD_BANK_PERSIST)
		begin
			bank_nv_ff <= sr_ff[7:0];
		end
	end

	// Volatile bank reloads from the persistent copy on soft reset; hard reset loads BANK_NV_RST
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			bank_vol_ff <= fsb_pkg::BANK_NV_RST;
		end else if (i_soft_reset) begin
			bank_vol_ff <= bank_nv_ff;
		end else if (accept && (cmd == fsb_pkg::FSB_CMD_BANK_PERSIST
			|| cmd == fsb_pkg::FSB_CMD_BANK_TEMP
			|| cmd == fsb_pkg::FSB_CMD_BANK_FREE)) begin
			bank_vol_ff <= sr_ff[7:0];
		end else if (accept && cmd == fsb_pkg::FSB_CMD_WIDE_ENTER) begin
			bank_vol_ff[fsb_pkg::BANK_WIDE_BIT] <= 1'b1;
		end else if (accept && cmd == fsb_pkg::FSB_CMD_WIDE_LEAVE) begin
			bank_vol_ff[fsb_pkg::BANK_WIDE_BIT] <= 1'b0;
		end
	end

	// Single open sector; a second open is ignored until closed
	always_ff @(posedge i_mclk) begin
		if (i_srst || i_soft_reset) begin
			open_valid_ff <= 1'b0;
			open_addr_ff <= 20'h0_0000;
		end else if (accept && cmd == fsb_pkg::FSB_CMD_CLOSE) begin
			open_valid_ff <= 1'b0;
		end else if (accept && !open_valid_ff
			&& (cmd == fsb_pkg::FSB_CMD_OPEN
			|| cmd == fsb_pkg::FSB_CMD_OPEN_WIDE)
			&& blk_prot(open_addr, i_block_protect_level,
			i_top_bottom_select)) begin
			open_valid_ff <= 1'b1;
			open_addr_ff <= open_addr[31:fsb_pkg::SECTOR_LSB];
		end
	end

	// Boot arming: taken from the enable bit one cycle after reset
	always_ff @(posedge i_mclk) begin
		if (i_srst || i_soft_reset) begin
			rearm_ff <= 1'b1;
			boot_armed_ff <= 1'b0;
		end else if (rearm_ff) begin
			rearm_ff <= 1'b0;
			boot_armed_ff <= boot_cfg_ff[fsb_pkg::BOOT_EN_BIT];
		end else if (cs_s2_ff && !cs_s3_ff && boot_frame_ff
			&& obits_ff >= 27'h8) begin
			boot_armed_ff <= 1'b0;
		end
	end

	assign o_boot_config = boot_cfg_ff;
	assign o_boot_armed = boot_armed_ff;
	assign o_op_pending = pend_ff;
	assign o_write_permit_latch = permit_ff;
	assign o_wide_address_on = bank_vol_ff[fsb_pkg::BANK_WIDE_BIT];
	assign o_bank_nonvolatile = bank_nv_ff;
	assign o_sector_open_valid = open_valid_ff;
	assign o_sector_open_addr = open_addr_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	property p_permit_cleared;
		$fell(pend_ff) |-> !permit_ff;
	endproperty
	a_permit_cleared: assert property (p_permit_cleared)
		else $error("permit latch still set after write");

	property p_no_unpermitted_cfg;
		(commit && cmd == fsb_pkg::FSB_CMD_CFG_WRITE && !permit_ff)
			|=> $stable(boot_cfg_ff) && !pend_ff;
	endproperty
	a_no_unpermitted_cfg: assert property (p_no_unpermitted_cfg)
		else $error("config changed without permit");

	property p_one_sector;
		open_valid_ff && $past(open_valid_ff) |-> $stable(open_addr_ff);
	endproperty
	a_one_sector: assert property (p_one_sector)
		else $error("open sector moved while open");

	property p_no_rearm;
		!boot_armed_ff && !rearm_ff && !i_soft_reset |=> !boot_armed_ff;
	endproperty
	a_no_rearm: assert property (p_no_rearm)
		else $error("boot stream rearmed without reset");

	property p_wide_enter;
		accept && cmd == fsb_pkg::FSB_CMD_WIDE_ENTER && !i_soft_reset
			|=> bank_vol_ff[7] && $stable(bank_nv_ff) && !pend_ff;
	endproperty
	a_wide_enter: assert property (p_wide_enter)
		else $error("wide address enter failed");

	property p_persist_both;
		accept && cmd == fsb_pkg::FSB_CMD_BANK_PERSIST && !i_soft_reset
			|=> bank_vol_ff == bank_nv_ff ##1 pend_ff;
	endproperty
	a_persist_both: assert property (p_persist_both)
		else $error("persistent bank write did not copy");

	property p_close;
		accept && cmd == fsb_pkg::FSB_CMD_CLOSE |=> !open_valid_ff;
	endproperty
	a_close: assert property (p_close)
		else $error("sector not closed");

	// Cycles spent pending; a repetition count would not follow WRITE_CYC
	logic [15:0] pend_len_ff;
	always_ff @(posedge i_mclk) begin
		if (i_srst || !pend_ff) begin
			pend_len_ff <= 16'h0000;
		end else begin
			pend_len_ff <= pend_len_ff + 16'h0001;
		end
	end

	property p_pend_length;
		$fell(pend_ff) && !$past(i_soft_reset)
			|-> pend_len_ff == 16'(WRITE_CYC);
	endproperty
	a_pend_length: assert property (p_pend_length)
		else $error("pending flag length wrong");

	property p_arm_at_release;
		$past(i_srst) && !i_srst ##1 !i_soft_reset
			|-> boot_armed_ff == boot_cfg_ff[0];
	endproperty
	a_arm_at_release: assert property (p_arm_at_release)
		else $error("boot arming does not follow enable bit");

	property p_open_protected;
		$rose(open_valid_ff) |-> $past(blk_prot(open_addr,
			i_block_protect_level, i_top_bottom_select));
	endproperty
	a_open_protected: assert property (p_open_protected)
		else $error("sector opened outside protected block");
endmodule
`default_nettype wire

/* design/fsb_pkg.sv */
`default_nettype none
package fsb_pkg;
	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_SECTOR_OPEN = 8'h26;
	localparam logic [7:0] OP_SECTOR_OPEN_WIDE = 8'h25;
	localparam logic [7:0] OP_SECTOR_CLOSE = 8'h24;
	localparam logic [7:0] OP_BOOT_CFG_READ = 8'h14;
	localparam logic [7:0] OP_BOOT_CFG_WRITE = 8'h15;
	localparam logic [7:0] OP_BANK_READ = 8'h16;
	localparam logic [7:0] OP_BANK_READ_ALT = 8'hC8;
	localparam logic [7:0] OP_BANK_WRITE_PERSIST = 8'h18;
	localparam logic [7:0] OP_BANK_WRITE_TEMP = 8'hC5;
	localparam logic [7:0] OP_BANK_WRITE_TEMP_FREE = 8'h17;
	localparam logic [7:0] OP_WIDE_ENTER = 8'hB7;
	localparam logic [7:0] OP_WIDE_LEAVE = 8'h29;
	localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
	// ==========================================================
	// Frame bit counts
	localparam logic [7:0] OPCODE_BITS = 8'h08;
	localparam logic [7:0] REPEAT_BITS = 8'h20;
	localparam logic [7:0] CNT_WRAP = 8'h48;
	localparam logic [7:0] BANK_FRAME_BITS = 8'h10;
	localparam logic [7:0] NARROW_ADDR_FRAME_BITS = 8'h20;
	localparam logic [7:0] WIDE_FRAME_BITS = 8'h28;
	// ==========================================================
	// Field positions
	localparam int BOOT_EN_BIT = 0;
	localparam int BOOT_DLY_LSB = 1;
	localparam int BOOT_DLY_MSB = 4;
	localparam int BOOT_ADDR_LSB = 9;
	localparam int BANK_WIDE_BIT = 7;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB = 16;
	localparam int BLOCK_MSB = 25;
	localparam logic [10:0] BLOCK_COUNT = 11'h400;
	// ==========================================================
	// Reset values
	localparam logic [31:0] BOOT_CFG_RST = 32'h0000_0000;
	localparam logic [7:0] BANK_NV_RST = 8'h00;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_TIME_NS = 1000;
	localparam int WRITE_CYCLES =
		(WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================================
	// Decoded frame kinds
	typedef enum logic [3:0] {
		FSB_CMD_NONE, FSB_CMD_OPEN, FSB_CMD_OPEN_WIDE, FSB_CMD_CLOSE,
		FSB_CMD_CFG_WRITE, FSB_CMD_BANK_PERSIST, FSB_CMD_BANK_TEMP,
		FSB_CMD_BANK_FREE, FSB_CMD_WIDE_ENTER, FSB_CMD_WIDE_LEAVE,
		FSB_CMD_PERMIT
	} fsb_cmd_type;
endpackage
`default_nettype wire

/* test/fsb_host.sv */
`default_nettype none
module fsb_host (
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_io,
	input wire logic [3:0] i_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 40;

	// Idle link: clock parked low, select high
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
	end

	// ==========================================================
	// One frame: nin bits sent, then nout bits read; w is 1 or 4
	// Host lines it is not using toggle so a stale level never helps
	task automatic xfer(input int w, input int nin, input logic [63:0] din,
		input int nout, output logic [63:0] dout);
		dout = '0;
		#13;
		o_cs_n = 1'b0;
		for (int i = nin - w; i >= 0; i -= w) begin
			o_io = (w == 4) ? din[i+:4] : {~o_io[3:1], din[i]};
			#HALF o_sck = 1'b1;
			#HALF o_sck = 1'b0;
		end
		for (int j = 0; j < nout; j += w) begin
			o_io = ~o_io;
			#HALF o_sck = 1'b1;
			if (w == 4) begin
				dout = {dout[59:0], i_pin};
			end else begin
				dout = {dout[62:0], i_pin[1]};
			end
			#HALF o_sck = 1'b0;
		end
		// Select rises only after the clock is back low
		#HALF o_cs_n = 1'b1;
		o_io = ~o_io;
		#HALF;
	endtask
endmodule
`default_nettype wire

/* test/tb_flash_sector_boot_bank_cmds.sv */
`default_nettype none
module tb_flash_sector_boot_bank_cmds;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic permit;
		logic [7:0] op;
		logic [7:0] data;
		logic [7:0] vol;
		logic [7:0] nv;
	} fsb_row_type;
	localparam logic [31:0] CFG = 32'h0002_4607;
	localparam logic [31:0] CFG_W = 32'h0746_0200;
	logic i_mclk, i_srst, i_soft_reset, i_four_line_command_mode;
	logic i_quad_lines_on, i_top_bottom_select, sck, cs_n;
	logic [3:0] i_block_protect_level, host_io, pin, io_out, io_oe, last_oe;
	logic [23:0] idx;
	logic [31:0] cfg;
	logic armed, pend, latch, wide, open_v, saw_pend;
	logic [7:0] nv;
	logic [19:0] open_a;
	logic [63:0] rd;
	int error_cnt, checks;
	fsb_row_type rows[7] = '{
		'{1'b0, fsb_pkg::OP_BANK_WRITE_TEMP_FREE, 8'h81, 8'h81, 8'h00},
		'{1'b0, fsb_pkg::OP_BANK_WRITE_TEMP, 8'h02, 8'h81, 8'h00},
		'{1'b1, fsb_pkg::OP_BANK_WRITE_TEMP, 8'h00, 8'h00, 8'h00},
		'{1'b1, fsb_pkg::OP_BANK_WRITE_PERSIST, 8'h01, 8'h01, 8'h01},
		'{1'b0, fsb_pkg::OP_BANK_WRITE_PERSIST, 8'h00, 8'h01, 8'h01},
		'{1'b0, fsb_pkg::OP_WIDE_ENTER, 8'h00, 8'h81, 8'h01},
		'{1'b0, fsb_pkg::OP_WIDE_LEAVE, 8'h00, 8'h01, 8'h01}
	};

	// Wire level from the DUT's enables; the host drives the rest
	assign pin = (io_oe & io_out) | (~io_oe & host_io);

	fsb_cmd #(.WRITE_CYC(4)) dut (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_soft_reset(i_soft_reset),
		.i_sck(sck),
		.i_cs_n(cs_n),
		.i_io_in(pin),
		.o_io_out(io_out),
		.o_io_oe(io_oe),
		.i_four_line_command_mode(i_four_line_command_mode),
		.i_quad_lines_on(i_quad_lines_on),
		.i_block_protect_level(i_block_protect_level),
		.i_top_bottom_select(i_top_bottom_select),
		.i_boot_data(8'hA5 ^ idx[7:0]),
		.o_boot_byte_index(idx),
		.o_boot_config(cfg),
		.o_boot_armed(armed),
		.o_op_pending(pend),
		.o_write_permit_latch(latch),
		.o_wide_address_on(wide),
		.o_bank_nonvolatile(nv),
		.o_sector_open_valid(open_v),
		.o_sector_open_addr(open_a)
	);

	fsb_host host (
		.o_sck(sck),
		.o_cs_n(cs_n),
		.o_io(host_io),
		.i_pin(pin)
	);

	// Control clock, 100 MHz
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	// Pending is short, so catch it with a sticky flag
	always @(posedge i_mclk) begin
		if (pend === 1'b1) saw_pend <= 1'b1;
	end

	// Last driver enables seen inside a frame
	always @(posedge sck) begin
		if (cs_n === 1'b0) last_oe <= io_oe;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic mcyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	// Commit lands a few cycles after select rises; bounded wait on pending
	task automatic settle;
		mcyc(8);
		for (int k = 0; k < 100 && pend !== 1'b0; k++) mcyc(1);
	endtask

	task automatic spi(input int nin, input logic [63:0] din, input int nout);
		host.xfer(1, nin, din, nout, rd);
		settle();
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#400_000;
		error_cnt++;
		$display("unexpected at %0t: watchdog", $time);
		end_of_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		i_srst = 1'b1;
		i_soft_reset = 1'b0;
		i_four_line_command_mode = 1'b0;
		i_quad_lines_on = 1'b0;
		i_block_protect_level = 4'hF;
		i_top_bottom_select = 1'b0;
		saw_pend = 1'b0;
		error_cnt = 0;
		checks = 0;
		mcyc(16);
		i_srst = 1'b0;
		mcyc(4);
		chk(cfg, fsb_pkg::BOOT_CFG_RST);
		chk(nv, fsb_pkg::BANK_NV_RST);
		chk(armed, 1'b0);
		// Bank writes and reads from the table
		foreach (rows[r]) begin
			if (rows[r].permit) spi(8, fsb_pkg::OP_WRITE_PERMIT, 0);
			if (rows[r].op == fsb_pkg::OP_WIDE_ENTER ||
				rows[r].op == fsb_pkg::OP_WIDE_LEAVE) begin
				spi(8, rows[r].op, 0);
			end else begin
				spi(16, {rows[r].op, rows[r].data}, 0);
			end
			spi(8, r[0] ? fsb_pkg::OP_BANK_READ_ALT : fsb_pkg::OP_BANK_READ, 16);
			chk(rd[15:0], {2{rows[r].vol}});
			chk(nv, rows[r].nv);
			chk(wide, rows[r].vol[7]);
			chk(latch, 1'b0);
		end
		// Sector open and close; bank byte is 01 here
		spi(32, {fsb_pkg::OP_SECTOR_OPEN, 24'h12_3ABC}, 0);
		chk(open_v, 1'b1);
		chk(open_a, 20'h0_1123);
		spi(32, {fsb_pkg::OP_SECTOR_OPEN, 24'h45_6000}, 0);
		chk(open_a, 20'h0_1123);
		spi(8, fsb_pkg::OP_SECTOR_CLOSE, 0);
		chk(open_v, 1'b0);
		spi(8, fsb_pkg::OP_WIDE_ENTER, 0);
		spi(40, {fsb_pkg::OP_SECTOR_OPEN, 32'h0345_6FFF}, 0);
		chk(open_a, 20'h0_3456);
		spi(8, fsb_pkg::OP_SECTOR_CLOSE, 0);
		spi(8, fsb_pkg::OP_WIDE_LEAVE, 0);
		spi(40, {fsb_pkg::OP_SECTOR_OPEN_WIDE, 32'h0234_5001}, 0);
		chk(open_a, 20'h0_2345);
		spi(8, fsb_pkg::OP_SECTOR_CLOSE, 0);
		i_block_protect_level = 4'h0;
		spi(40, {fsb_pkg::OP_SECTOR_OPEN_WIDE, 32'h0234_5001}, 0);
		chk(open_v, 1'b0);
		i_block_protect_level = 4'hF;
		// Boot config write paths
		saw_pend = 1'b0;
		spi(16, {fsb_pkg::OP_BANK_WRITE_TEMP_FREE, 8'h01}, 0);
		chk(saw_pend, 1'b1);
		spi(40, {fsb_pkg::OP_BOOT_CFG_WRITE, CFG_W}, 0);
		chk(cfg, 32'h0);
		spi(8, fsb_pkg::OP_WRITE_PERMIT, 0);
		spi(39, {fsb_pkg::OP_BOOT_CFG_WRITE, CFG_W[31:1]}, 0);
		chk(cfg, 32'h0);
		spi(8, fsb_pkg::OP_WRITE_PERMIT, 0);
		saw_pend = 1'b0;
		spi(40, {fsb_pkg::OP_BOOT_CFG_WRITE, CFG_W}, 0);
		chk(cfg, CFG);
		chk(saw_pend, 1'b1);
		chk(latch, 1'b0);
		spi(8, fsb_pkg::OP_BOOT_CFG_READ, 64);
		chk(rd, {2{CFG_W}});
		spi(8, fsb_pkg::OP_BANK_READ, 8);
		chk(last_oe, 4'h2);
		// Four-line bank read, two bytes
		i_four_line_command_mode = 1'b1;
		host.xfer(4, 8, fsb_pkg::OP_BANK_READ, 16, rd);
		settle();
		chk(rd[15:0], 16'h0101);
		chk(last_oe, 4'hF);
		i_four_line_command_mode = 1'b0;
		// Boot stream after soft reset, single then quad; delay is 3
		for (int q = 0; q < 2; q++) begin
			i_quad_lines_on = q[0];
			i_soft_reset = 1'b1;
			mcyc(1);
			i_soft_reset = 1'b0;
			mcyc(4);
			chk(armed, 1'b1);
			host.xfer(q ? 4 : 1, q ? 16 : 4, 64'h0, 16, rd);
			settle();
			chk(rd[15:0], 16'hA5A4);
			chk(armed, 1'b0);
			chk(idx, 24'h00_0002);
			spi(8, fsb_pkg::OP_BANK_READ, 8);
			chk(rd[7:0], 8'h01);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
